// File: bench/psfr_reader.sv
// Reader model draining the receive buffer for the user logic
`timescale 1ns/1ps
module psfr_reader (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic go,
  input  wire logic rxBufferEmptyLow,
  input  wire logic rxBufferLastWordLow,
  output logic      readRequestLow
);
  logic readReq_r;
  // Stop once the last word is taken; empty decides whether to go on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readReq_r <= 1'b0;
    end else begin
      readReq_r <= go & rxBufferEmptyLow & ~(readReq_r & ~rxBufferLastWordLow);
    end
  end
  assign readRequestLow = ~readReq_r;
endmodule

// File: bench/tb_psfr_top.sv
// Self-checking bench for the packet sink read port and status
`timescale 1ns/1ps
module tb_psfr_top;
  import psfr_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, divReset_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic        rxBufferClearLow = 1'b1, sinkEnableIn = 1'b0, delayCalibratedReady = 1'b0;
  logic        linkLocked = 1'b0, go = 1'b0, readRequestLow, avsWaitrequest, linkStatusClockOut;
  logic [3:0]  avsAddress = 4'h0;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, q;
  logic [1:0]  statusCode = 2'h1, linkStatusLines;
  logic [7:0]  violationCauseVector;
  logic [7:0]  ev [4] = '{8'h10, 8'h20, 8'h08, 8'h02};
  logic        outOfFrameFlag, protocolViolationFlag, trainingSeenFlag, readWordValid;
  logic        rxBufferEmptyLow, rxBufferLastWordLow, rxBufferNearlyFullLow, rxBufferOverrunLow;
  psfr_beat_t  linkBeat = '0;
  psfr_entry_t readOut, rq[$];
  int          fails = 0, compares = 0, n;

  // 200 MHz clock
  always #2.5 clk = ~clk;
  psfr_top psfr_top_inst (.clk, .reset_n, .divReset_n, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest, .rxBufferClearLow,
    .sinkEnableIn, .delayCalibratedReady, .linkLocked, .linkBeat, .statusCode, .linkStatusLines,
    .linkStatusClockOut, .outOfFrameFlag, .protocolViolationFlag, .violationCauseVector,
    .trainingSeenFlag, .readRequestLow, .readOut, .readWordValid, .rxBufferEmptyLow,
    .rxBufferLastWordLow, .rxBufferNearlyFullLow, .rxBufferOverrunLow);
  psfr_reader psfr_reader_inst (.clk, .reset_n, .go, .rxBufferEmptyLow, .rxBufferLastWordLow,
    .readRequestLow);
  // Collect words at the falling edge, clear of the launching edge
  always @(negedge clk) if (readWordValid === 1'b1) rq.push_back(readOut);

  task conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held to the edge that samples waitrequest low; data taken at that edge
  task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    {avsRead, avsAddress} <= {1'b1, a};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 20);
    q = avsReaddata;
    avsRead <= 1'b0;
    chk(nm, e, q);
    if (n == 20) begin
      fails++;
      conclude();
    end
  endtask
  task beat(input logic c, psfr_ctl_t t, logic s, psfr_eop_t e, logic [7:0] ch, logic p,
            logic [63:0] d);
    @(posedge clk);
    linkBeat <= '{1'b1, c, t, s, e, 3'h3, ch, p, d};
  endtask
  task idle;
    @(posedge clk);
    linkBeat <= '0;
    @(negedge clk);
  endtask
  task pkt(input logic [7:0] ch, input logic p, input logic [63:0] d);
    beat(1, CT_PAYLOAD, 1, EOP_NONE, ch, p, 0);
    beat(0, CT_IDLE, 0, EOP_NONE, 0, 0, d);
    beat(1, CT_IDLE, 0, EOP_ABORT, 0, 0, 0);
    idle();
  endtask
  // Frame needs the synchronised ready, so the wait is bounded, not fixed
  task waitFrame;
    n = 0;
    while (outOfFrameFlag !== 1'b0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    // Status lines follow the frame flag one edge later
    @(negedge clk);
    chk("inFrame", {1'b0, statusCode}, {outOfFrameFlag, linkStatusLines});
    if (n == 50) conclude();
  endtask

  task t_reset;
    chk("oof", 9'h1c7, {outOfFrameFlag, linkStatusLines, protocolViolationFlag,
      trainingSeenFlag, rxBufferEmptyLow, rxBufferLastWordLow, rxBufferNearlyFullLow,
      rxBufferOverrunLow});
    // Status clock runs at a quarter rate: half of any eight cycles high
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += (linkStatusClockOut === 1'b1);
    end
    chk("statusClock", 4, n);
    rd(REG_CFG, 32'(AF_RST), "threshold");
    rd(4'hc, 32'h0, "unmapped");
    $display("reset test done");
  endtask
  task t_packet;
    @(posedge clk);
    {sinkEnableIn, linkLocked, delayCalibratedReady} <= 3'h7;
    waitFrame();
    beat(1, CT_PAYLOAD, 1, EOP_NONE, 8'h05, 1, 0);
    beat(0, CT_IDLE, 0, EOP_NONE, 0, 0, 64'h1111);
    pkt(8'h05, 0, 64'h2222);
    rd(REG_LEVEL, 32'h2, "level");
    chk("lastWord", 1, rxBufferLastWordLow);
    @(posedge clk);
    go <= 1'b1;
    n = 0;
    while (rq.size() < 2 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk("words", 2, rq.size());
    if (n == 30) conclude();
    chk("first", {64'h1111, 8'h05, 7'b1000110}, {rq[0].readWord, rq[0].readChannelNumber,
      rq[0][6:0]});
    chk("end", {64'h2222, 3'h3, 7'b1110000}, {rq[1].readWord, rq[1].readByteModulo,
      rq[1][6:0]});
    chk("empty", 0, rxBufferEmptyLow);
    @(posedge clk);
    go <= 1'b0;
    rq.delete();
    $display("packet test done");
  endtask
  task t_errors;
    for (int i = 0; i < 4; i++) begin
      beat(1, psfr_ctl_t'(i == 0 ? CT_RSVD : CT_IDLE), 0,
           psfr_eop_t'(i == 3 ? EOP_END : EOP_NONE), {7'h0, i == 1}, i == 2, 0);
      idle();
      chk("cause", {1'b1, ev[i]}, {protocolViolationFlag, violationCauseVector});
      @(negedge clk);
      chk("pulse", 0, {protocolViolationFlag, violationCauseVector});
    end
    // Back-to-back starts: spacing too short and a payload word with no data
    beat(1, CT_PAYLOAD, 1, EOP_NONE, 0, 0, 0);
    beat(1, CT_PAYLOAD, 1, EOP_NONE, 0, 0, 0);
    idle();
    chk("sopGap", 9'h105, {protocolViolationFlag, violationCauseVector});
    repeat (5) beat(1, CT_TRAIN, 0, EOP_NONE, 0, 0, 0);
    // No idle wait here, so the first high cycle is counted
    @(posedge clk);
    linkBeat <= '0;
    n = 0;
    repeat (15) begin
      @(negedge clk);
      n += (trainingSeenFlag === 1'b1);
    end
    chk("trainLen", 32'(TRAIN_BEATS), n);
    $display("error and training test done");
  endtask
  // Disable must keep the stored word; a clear must drop it and hunt for a start
  task t_hold;
    pkt(8'h02, 0, 64'h3333);
    chk("lastWord", 0, rxBufferLastWordLow);
    @(posedge clk);
    sinkEnableIn <= 1'b0;
    pkt(8'h02, 0, 64'h4444);
    chk("disabled", 4'he, {outOfFrameFlag, linkStatusLines, trainingSeenFlag});
    rd(REG_LEVEL, 32'h1, "kept");
    @(posedge clk);
    sinkEnableIn <= 1'b1;
    waitFrame();
    @(posedge clk);
    rxBufferClearLow <= 1'b0;
    @(posedge clk);
    rxBufferClearLow <= 1'b1;
    beat(0, CT_IDLE, 0, EOP_NONE, 0, 0, 64'h5555);
    beat(1, CT_IDLE, 0, EOP_END, 0, 0, 0);
    idle();
    chk("cleared", 0, {rxBufferEmptyLow, outOfFrameFlag});
    rd(REG_LEVEL, 32'h0, "discard");
    $display("hold and clear test done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    divReset_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_packet();
    t_errors();
    t_hold();
    conclude();
  end
endmodule

// File: rtl/psfr_mem.sv
// Receive buffer storage with a registered read port
`timescale 1ns/1ps
module psfr_mem (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        wrEn,
  input  wire logic [psfr_pkg::PTR_W-1:0]  wrAddr,
  input  wire logic [psfr_pkg::ENTRY_W-1:0] wrData,
  input  wire logic                        rdEn,
  input  wire logic [psfr_pkg::PTR_W-1:0]  rdAddr,
  output logic      [psfr_pkg::ENTRY_W-1:0] rdData
);
  import psfr_pkg::*;

  logic [ENTRY_W-1:0] store [DEPTH];
  logic [ENTRY_W-1:0] rdData_nxt;

  // Array is not reset; pointers guard stale contents
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // Read data holds between reads
  always_comb begin
    rdData_nxt = rdEn ? store[rdAddr] : rdData;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= '0;
    end else begin
      rdData <= rdData_nxt;
    end
  end
endmodule

// File: rtl/psfr_top.sv
// Packet sink: link beat decode, receive buffer, read port and status
// How it works
// - Global reset clears state (threshold to 16, not divider or array), forces out-of-frame
// - Disable leaves frame, keeps buffer, sends 11
// - Buffer clear keeps frame, hunts for SOP
// - Out-of-frame follows enable and link sync
// - Violation flag with cause vector, top bits zero
// - Six cause bits for six protocol faults
// - Training flag high for five clock cycles
// - Read request low gives word next edge
// - Read word width 64, 128 by constant
// - Byte modulo marks valid bytes at end
// - Channel, start and end flags per word
// - Abort flag only together with end flag
// - Empty flag comes with last word out
// - Last-word flag when exactly one stored
// - Valid qualifies word and all its flags
// - End and start parity errors on final word
// - Burst flag on unterminated non-credit end
// - Orphan flag until payload word then data
// - Nearly-full from configured free-space threshold
// - Overrun flag blocks all further writes
// - Threshold clamped to range 1 to 508
`timescale 1ns/1ps
module psfr_top (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       divReset_n,
  input  wire logic [3:0]                 avsAddress,
  input  wire logic                       avsRead,
  input  wire logic                       avsWrite,
  input  wire logic [31:0]                avsWritedata,
  input  wire logic [3:0]                 avsByteenable,
  output logic      [31:0]                avsReaddata,
  output logic                            avsWaitrequest,
  input  wire logic                       rxBufferClearLow,
  input  wire logic                       sinkEnableIn,
  input  wire logic                       delayCalibratedReady,
  input  wire logic                       linkLocked,
  input  wire psfr_pkg::psfr_beat_t       linkBeat,
  input  wire logic [1:0]                 statusCode,
  output logic      [1:0]                 linkStatusLines,
  output logic                            linkStatusClockOut,
  output logic                            outOfFrameFlag,
  output logic                            protocolViolationFlag,
  output logic      [psfr_pkg::CAUSE_W-1:0] violationCauseVector,
  output logic                            trainingSeenFlag,
  input  wire logic                       readRequestLow,
  output psfr_pkg::psfr_entry_t           readOut,
  output logic                            readWordValid,
  output logic                            rxBufferEmptyLow,
  output logic                            rxBufferLastWordLow,
  output logic                            rxBufferNearlyFullLow,
  output logic                            rxBufferOverrunLow
);
  import psfr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]         rdySync_r, rdySync_nxt;
  logic               rdyLvl_r, rdyLvl_nxt;
  logic               oof_r, oof_nxt;
  logic [1:0]         stat_r, stat_nxt;
  logic [DIV_W-1:0]   div_r, div_nxt;
  psfr_state_t        state_r, state_nxt;
  psfr_entry_t        pend_r, pend_nxt, wrEntry;
  logic               pendV_r, pendV_nxt;
  logic               inPay_r, inPay_nxt;
  logic [CHAN_W-1:0]  chan_r, chan_nxt;
  logic               sopNext_r, sopNext_nxt;
  logic               startPar_r, startPar_nxt;
  logic [CREDIT_W-1:0] words_r, words_nxt;
  logic [GAP_W-1:0]   sopGap_r, sopGap_nxt;
  logic               prevData_r, prevData_nxt;
  logic               prevPay_r, prevPay_nxt;
  logic [TRN_W-1:0]   trnRun_r, trnRun_nxt;
  logic [TRN_W-1:0]   trnHold_r, trnHold_nxt;
  logic [CAUSE_W-1:0] cause_r, cause_nxt;
  logic               wrEn, wrGo, rdGo;
  logic [PTR_W-1:0]   wptr_r, wptr_nxt, rptr_r, rptr_nxt;
  logic [CNT_W-1:0]   count_r, count_nxt, freeCnt;
  logic               valid_r, valid_nxt;
  logic [8:0]         cfgThr_r, cfgThr_nxt, thr;
  logic               ack_r, ack_nxt;
  logic [31:0]        rdReg_r, rdReg_nxt;
  logic               avsReq;
  logic [ENTRY_W-1:0] memOut;

  // ----------------------------------------------------------------
  // Frame, calibration sync and status lines
  // ----------------------------------------------------------------
  // Ready comes from the divided receive clock, so it is resynchronised
  always_comb begin
    rdySync_nxt = {rdySync_r[1:0], delayCalibratedReady};
    rdyLvl_nxt  = (rdySync_r[1] == rdySync_r[2]) ? rdySync_r[2] : rdyLvl_r;
    oof_nxt     = !sinkEnableIn || !linkLocked || !rdyLvl_r;
    stat_nxt    = oof_r ? FRAMING : statusCode;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdySync_r <= '0;
      rdyLvl_r  <= 1'b0;
      oof_r     <= 1'b1;
      stat_r    <= FRAMING;
    end else begin
      rdySync_r <= rdySync_nxt;
      rdyLvl_r  <= rdyLvl_nxt;
      oof_r     <= oof_nxt;
      stat_r    <= stat_nxt;
    end
  end

  // Own reset so the status clock keeps running through global reset
  always_comb begin
    div_nxt = div_r + 1'b1;
  end

  always_ff @(posedge clk or negedge divReset_n) begin
    if (!divReset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign linkStatusLines    = stat_r;
  assign linkStatusClockOut = div_r[DIV_W-1];
  assign outOfFrameFlag     = oof_r;

  // ----------------------------------------------------------------
  // Link beat decode and word assembly
  // ----------------------------------------------------------------
  // A word is held one beat because its end marking rides on the next control word
  always_comb begin
    pend_nxt     = pend_r;
    pendV_nxt    = pendV_r;
    inPay_nxt    = inPay_r;
    chan_nxt     = chan_r;
    sopNext_nxt  = sopNext_r;
    startPar_nxt = startPar_r;
    words_nxt    = words_r;
    prevData_nxt = prevData_r;
    prevPay_nxt  = prevPay_r;
    state_nxt    = state_r;
    trnRun_nxt   = trnRun_r;
    trnHold_nxt  = (trnHold_r != '0) ? trnHold_r - 1'b1 : trnHold_r;
    sopGap_nxt   = (sopGap_r < MIN_SOP_GAP) ? sopGap_r + 1'b1 : sopGap_r;
    cause_nxt    = '0;
    wrEntry      = pend_r;
    wrEn         = 1'b0;
    if (linkBeat.valid && !oof_r) begin
      prevData_nxt = !linkBeat.isCtl;
      prevPay_nxt  = linkBeat.isCtl && (linkBeat.ctlType == CT_PAYLOAD);
      if (linkBeat.isCtl) begin
        // Protocol checks not tied to any packet
        cause_nxt[CAUSE_PLD]  = prevPay_r;
        cause_nxt[CAUSE_EOPD] = (linkBeat.eop != EOP_NONE) && !prevData_r;
        cause_nxt[CAUSE_PAR]  = linkBeat.dip4Err && ((linkBeat.ctlType == CT_TRAIN) ||
                                (linkBeat.ctlType == CT_IDLE));
        cause_nxt[CAUSE_RSVD] = (linkBeat.ctlType == CT_RSVD);
        cause_nxt[CAUSE_ADDR] = (linkBeat.chan != '0) && ((linkBeat.ctlType == CT_IDLE) ||
                                (linkBeat.ctlType == CT_RSVD));
        if ((linkBeat.ctlType == CT_PAYLOAD) && linkBeat.sop) begin
          cause_nxt[CAUSE_SOP] = (sopGap_r < MIN_SOP_GAP);
          sopGap_nxt = '0;
        end
        // Close the held word with this control word's end marking
        if (pendV_r) begin
          wrEntry.endWordParityError   = linkBeat.dip4Err;
          wrEntry.startWordParityError = startPar_r;
          if (linkBeat.eop != EOP_NONE) begin
            wrEntry.readPacketEnd  = 1'b1;
            wrEntry.readAbortFlag  = (linkBeat.eop == EOP_ABORT);
            wrEntry.readByteModulo = linkBeat.mod;
          end else begin
            wrEntry.unterminatedBurstFlag = (words_r != '0);
          end
          wrEn      = 1'b1;
          pendV_nxt = 1'b0;
        end
        inPay_nxt = (linkBeat.ctlType == CT_PAYLOAD);
        if (linkBeat.ctlType == CT_PAYLOAD) begin
          chan_nxt     = linkBeat.chan;
          sopNext_nxt  = linkBeat.sop;
          startPar_nxt = linkBeat.dip4Err;
          words_nxt    = '0;
          if ((state_r == ST_HUNT) && linkBeat.sop) begin
            state_nxt = ST_RUN;
          end
        end
        // Training pattern: five consecutive training beats
        if (linkBeat.ctlType == CT_TRAIN) begin
          trnRun_nxt = trnRun_r + 1'b1;
          if (trnRun_r == TRAIN_BEATS - 1'b1) begin
            trnRun_nxt  = '0;
            trnHold_nxt = TRAIN_BEATS;
          end
        end else begin
          trnRun_nxt = '0;
        end
      end else if (state_r == ST_RUN) begin
        // A new data word pushes out the held one without an end
        wrEn = pendV_r;
        pend_nxt = '0;
        pend_nxt.readWord          = linkBeat.data;
        pend_nxt.readChannelNumber = inPay_r ? chan_r : '0;
        pend_nxt.readPacketStart   = sopNext_r && inPay_r;
        pend_nxt.orphanDataFlag    = !inPay_r;
        pendV_nxt   = 1'b1;
        sopNext_nxt = 1'b0;
        words_nxt   = words_r + 1'b1;
      end
    end
    // Overflow drops the word and freezes writes until the buffer is cleared
    if (wrEn && (count_r == CNT_W'(DEPTH)) && !rdGo) begin
      state_nxt = ST_OVER;
      pendV_nxt = 1'b0;
    end
    if (state_r == ST_OVER) begin
      state_nxt = ST_OVER;
      pendV_nxt = 1'b0;
    end
    // Leaving frame drops the unfinished word, keeps what is stored
    if (oof_r) begin
      pendV_nxt   = 1'b0;
      inPay_nxt   = 1'b0;
      trnRun_nxt  = '0;
      trnHold_nxt = '0;
    end
    if (!rxBufferClearLow) begin
      pendV_nxt = 1'b0;
      inPay_nxt = 1'b0;
      state_nxt = ST_HUNT;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r     <= '0;
      pendV_r    <= 1'b0;
      inPay_r    <= 1'b0;
      chan_r     <= '0;
      sopNext_r  <= 1'b0;
      startPar_r <= 1'b0;
      words_r    <= '0;
      sopGap_r   <= MIN_SOP_GAP;
      prevData_r <= 1'b0;
      prevPay_r  <= 1'b0;
      state_r    <= ST_HUNT;
      trnRun_r   <= '0;
      trnHold_r  <= '0;
      cause_r    <= '0;
    end else begin
      pend_r     <= pend_nxt;
      pendV_r    <= pendV_nxt;
      inPay_r    <= inPay_nxt;
      chan_r     <= chan_nxt;
      sopNext_r  <= sopNext_nxt;
      startPar_r <= startPar_nxt;
      words_r    <= words_nxt;
      sopGap_r   <= sopGap_nxt;
      prevData_r <= prevData_nxt;
      prevPay_r  <= prevPay_nxt;
      state_r    <= state_nxt;
      trnRun_r   <= trnRun_nxt;
      trnHold_r  <= trnHold_nxt;
      cause_r    <= cause_nxt;
    end
  end

  assign violationCauseVector  = cause_r;
  assign protocolViolationFlag = |cause_r;
  assign trainingSeenFlag      = (trnHold_r != '0);

  // ----------------------------------------------------------------
  // Buffer pointers and read port
  // ----------------------------------------------------------------
  assign wrGo = wrEn && (state_r == ST_RUN) && ((count_r != CNT_W'(DEPTH)) || rdGo) &&
                rxBufferClearLow;
  assign rdGo = !readRequestLow && (count_r != '0) && rxBufferClearLow;

  always_comb begin
    wptr_nxt  = wrGo ? wptr_r + 1'b1 : wptr_r;
    rptr_nxt  = rdGo ? rptr_r + 1'b1 : rptr_r;
    count_nxt = count_r + CNT_W'(wrGo) - CNT_W'(rdGo);
    valid_nxt = rdGo;
    if (!rxBufferClearLow) begin
      wptr_nxt  = '0;
      rptr_nxt  = '0;
      count_nxt = '0;
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
      valid_r <= 1'b0;
    end else begin
      wptr_r  <= wptr_nxt;
      rptr_r  <= rptr_nxt;
      count_r <= count_nxt;
      valid_r <= valid_nxt;
    end
  end

  psfr_mem u_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .wrEn    (wrGo),
    .wrAddr  (wptr_r),
    .wrData  (wrEntry),
    .rdEn    (rdGo),
    .rdAddr  (rptr_r),
    .rdData  (memOut)
  );

  // Threshold is free locations, clamped into the legal range
  assign thr     = (cfgThr_r < AF_MIN) ? AF_MIN : ((cfgThr_r > AF_MAX) ? AF_MAX : cfgThr_r);
  assign freeCnt = CNT_W'(DEPTH) - count_r;

  assign readOut               = memOut;
  assign readWordValid         = valid_r;
  assign rxBufferEmptyLow      = (count_r != '0);
  assign rxBufferLastWordLow   = (count_r != CNT_W'(1));
  assign rxBufferNearlyFullLow = (freeCnt > {1'b0, thr});
  assign rxBufferOverrunLow    = (state_r != ST_OVER);

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state on every access
  // ----------------------------------------------------------------
  assign avsReq         = avsRead || avsWrite;
  assign avsWaitrequest = avsReq && !ack_r;
  assign avsReaddata    = rdReg_r;

  always_comb begin
    ack_nxt    = avsReq && !ack_r;
    rdReg_nxt  = rdReg_r;
    cfgThr_nxt = cfgThr_r;
    if (avsRead && !ack_r) begin
      case (avsAddress)
        REG_CFG:   rdReg_nxt = 32'(cfgThr_r);
        REG_STAT:  rdReg_nxt = 32'({trainingSeenFlag, protocolViolationFlag,
                               rxBufferOverrunLow, rxBufferNearlyFullLow,
                               rxBufferLastWordLow, rxBufferEmptyLow, oof_r});
        REG_LEVEL: rdReg_nxt = 32'(count_r);
        default:   rdReg_nxt = '0;
      endcase
    end
    // Write lands at the edge where waitrequest is low
    if (avsWrite && ack_r && (avsAddress == REG_CFG)) begin
      if (avsByteenable[0]) begin
        cfgThr_nxt[7:0] = avsWritedata[7:0];
      end
      if (avsByteenable[1]) begin
        cfgThr_nxt[8] = avsWritedata[8];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r    <= 1'b0;
      rdReg_r  <= '0;
      cfgThr_r <= AF_RST;
    end else begin
      ack_r    <= ack_nxt;
      rdReg_r  <= rdReg_nxt;
      cfgThr_r <= cfgThr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_oof_on_disable: assert property (!sinkEnableIn |=> outOfFrameFlag)
    else $error("out of frame not raised on disable");
  a_framing_when_oof: assert property (outOfFrameFlag |=> linkStatusLines == FRAMING)
    else $error("framing not sent while out of frame");
  a_cause_with_flag: assert property (violationCauseVector[7:6] == 2'h0 &&
    protocolViolationFlag == (violationCauseVector != '0))
    else $error("cause vector and violation flag disagree");
  a_train_length: assert property ($rose(trainingSeenFlag) |->
    trainingSeenFlag[*5] ##1 !trainingSeenFlag)
    else $error("training flag length wrong");
  a_read_latency: assert property ((!readRequestLow && rxBufferEmptyLow &&
    rxBufferClearLow) |=> readWordValid)
    else $error("read word not valid one edge after request");
  a_valid_cause: assert property (readWordValid |-> $past(!readRequestLow))
    else $error("valid without a request");
  a_abort_with_end: assert property (readWordValid && readOut.readAbortFlag |->
    readOut.readPacketEnd)
    else $error("abort without end");
  a_burst_no_end: assert property (readWordValid && readOut.unterminatedBurstFlag |->
    !readOut.readPacketEnd && !readOut.readAbortFlag)
    else $error("burst flag with end marking");
  a_empty_last_word: assert property ((!rxBufferLastWordLow && !readRequestLow && !wrGo &&
    rxBufferClearLow) |=> !rxBufferEmptyLow && readWordValid)
    else $error("empty not shown with last word");
  a_overrun_blocks: assert property (!rxBufferOverrunLow |-> !wrGo)
    else $error("write during overrun");
  a_clear_empties: assert property (!rxBufferClearLow |=> !rxBufferEmptyLow && !readWordValid)
    else $error("buffer clear did not empty");
endmodule

// File: shared/psfr_pkg.sv
// Shared constants and types of the packet sink receive buffer and read port
package psfr_pkg;
  // ----------------------------------------------------------------
  // Widths and depth
  // ----------------------------------------------------------------
  localparam int DATA_W   = 64;
  localparam int MOD_W    = $clog2(DATA_W / 8);
  localparam int CHAN_W   = 8;
  localparam int DEPTH    = 512;
  localparam int PTR_W    = 9;
  localparam int CNT_W    = 10;
  localparam int CAUSE_W  = 8;
  localparam int CREDIT_W = 1;                  // Credit is 2 words
  localparam int GAP_W    = 3;
  localparam int TRN_W    = 3;
  localparam int DIV_W    = 2;                  // Status clock at 1/4 rate

  // ----------------------------------------------------------------
  // Timing and limits
  // ----------------------------------------------------------------
  localparam logic [GAP_W-1:0] MIN_SOP_GAP = 3'h2;
  localparam logic [TRN_W-1:0] TRAIN_BEATS = 3'h5;
  localparam logic [8:0]       AF_MIN      = 9'h001;
  localparam logic [8:0]       AF_MAX      = 9'h1fc;
  localparam logic [8:0]       AF_RST      = 9'h010;
  localparam logic [1:0]       FRAMING     = 2'h3;

  // ----------------------------------------------------------------
  // Cause bits and register map
  // ----------------------------------------------------------------
  localparam int CAUSE_SOP  = 0;
  localparam int CAUSE_EOPD = 1;
  localparam int CAUSE_PLD  = 2;
  localparam int CAUSE_PAR  = 3;
  localparam int CAUSE_RSVD = 4;
  localparam int CAUSE_ADDR = 5;
  localparam logic [3:0] REG_CFG   = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_LEVEL = 4'h8;

  typedef enum logic [1:0] {CT_IDLE, CT_PAYLOAD, CT_TRAIN, CT_RSVD} psfr_ctl_t;
  typedef enum logic [1:0] {EOP_NONE, EOP_ABORT, EOP_END} psfr_eop_t;
  typedef enum logic [1:0] {ST_HUNT, ST_RUN, ST_OVER} psfr_state_t;

  // One decoded beat from the link deserializer
  typedef struct packed {
    logic              valid;
    logic              isCtl;
    psfr_ctl_t         ctlType;
    logic              sop;
    psfr_eop_t         eop;
    logic [MOD_W-1:0]  mod;
    logic [CHAN_W-1:0] chan;
    logic              dip4Err;
    logic [DATA_W-1:0] data;
  } psfr_beat_t;

  // One stored word with its qualifiers
  typedef struct packed {
    logic [DATA_W-1:0] readWord;
    logic [CHAN_W-1:0] readChannelNumber;
    logic [MOD_W-1:0]  readByteModulo;
    logic              readPacketStart;
    logic              readPacketEnd;
    logic              readAbortFlag;
    logic              endWordParityError;
    logic              startWordParityError;
    logic              unterminatedBurstFlag;
    logic              orphanDataFlag;
  } psfr_entry_t;

  localparam int ENTRY_W = $bits(psfr_entry_t);
endpackage
